// ---- shared/acs_params.svh ----
// constants for the converter channel-select and power control block
// assumes nothing; definitions only, included by bare name
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout, falling edges counted from zero, rising edges for ACS_CTRL_LAST
// ----------------------------------------------------------------------
`define ACS_CONV_LAST 4'hf
`define ACS_TRACK_START 4'h0
`define ACS_HOLD_START 4'h3
`define ACS_CODE_FIRST 4'h4
`define ACS_CODE_LAST 4'hd
`define ACS_CTRL_LAST 4'h7

// ----------------------------------------------------------------------
// control byte and channel select
// ----------------------------------------------------------------------
`define ACS_CTRL_BITS 8
`define ACS_CHAN_MSB 5
`define ACS_CHAN_LSB 3
`define ACS_NUM_CHAN 8
`define ACS_CHAN_DEFAULT 3'h0
`define ACS_INPUT_EN_RST 8'h01

// ----------------------------------------------------------------------
// result and buffering
// ----------------------------------------------------------------------
`define ACS_CODE_BITS 10
`define ACS_CODE_ZERO 10'h000
`define ACS_FIFO_DEPTH 16

`endif

// ---- shared/acs_pkg.sv ----
// types used by the converter control block; its result buffer keeps its own state type
// assumes acs_params.svh on the include path
`include "acs_params.svh"

package acs_pkg;

	typedef logic [`ACS_CODE_BITS-1:0] acs_code_t;
	typedef logic [2:0] acs_chan_t;

	typedef enum logic [3:0] {
		ST_WAIT_CHAN = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_FETCH = 4'h4,
		ST_OFFER = 4'h8
	} acs_state_t;

	// system clock domain
	typedef struct packed {
		acs_state_t state;
		acs_chan_t chan;
		logic [`ACS_NUM_CHAN-1:0] inputEn;
		logic strobe;
		logic chanSeen;
		logic [1:0] chanSync;
		logic [1:0] ackSync;
		acs_code_t holdCode;
		logic readyTog;
	} acs_sys_t;

	// serial clock rising edges, cleared with the frame
	typedef struct packed {
		logic [3:0] riseCnt;
		logic [`ACS_CTRL_BITS-2:0] ctrlShift;
	} acs_rise_frame_t;

	// serial clock rising edges, kept across frames
	typedef struct packed {
		acs_chan_t nextChan;
		logic chanTog;
	} acs_rise_keep_t;

	// serial clock falling edges, cleared with the frame
	typedef struct packed {
		logic [3:0] fallCnt;
		acs_code_t codeShift;
		logic dout;
		logic oe;
		logic powered;
		logic track;
	} acs_fall_frame_t;

	// serial clock falling edges, kept across frames
	typedef struct packed {
		logic ackTog;
		logic [1:0] rdySync;
	} acs_fall_keep_t;

endpackage

// ---- shared/acs_stream_if.sv ----
// valid/ready word stream between the control block and its buffer
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none

interface acs_stream_if #(
	parameter int W = 10
) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- logic/acs_fifo.sv ----
// result buffer: flip-flop FIFO with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_fifo #(
	parameter int WIDTH = `ACS_CODE_BITS,
	parameter int DEPTH = `ACS_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	acs_stream_if.snk fill,
	acs_stream_if.src drain
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
		logic inReady;
		logic outValid;
	} acs_fifo_state_t;

	acs_fifo_state_t fifoQ;
	acs_fifo_state_t fifoD;
	logic push;
	logic pop;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		fifoD = fifoQ;
		push = fill.valid && fifoQ.inReady;
		pop = drain.ready && fifoQ.outValid;
		if (push) begin
			fifoD.mem[fifoQ.wrPtr] = fill.data;
			fifoD.wrPtr = (fifoQ.wrPtr == AW'(DEPTH - 1)) ? '0 : fifoQ.wrPtr + 1'b1;
		end
		if (pop) begin
			fifoD.rdPtr = (fifoQ.rdPtr == AW'(DEPTH - 1)) ? '0 : fifoQ.rdPtr + 1'b1;
		end
		fifoD.count = fifoQ.count + (AW + 1)'(push) - (AW + 1)'(pop);
		// flags registered so both sides see flop outputs
		fifoD.inReady = (fifoD.count != (AW + 1)'(DEPTH));
		fifoD.outValid = (fifoD.count != '0);
	end

	assign fill.ready = fifoQ.inReady;
	assign drain.valid = fifoQ.outValid;
	assign drain.data = fifoQ.mem[fifoQ.rdPtr];

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifoQ <= '{inReady: 1'b1, default: '0};
		end else begin
			fifoQ <= fifoD;
		end
	end
endmodule

`default_nettype wire

// ---- logic/acs_top.sv ----
// converter frame control: channel select, result shift-out, power control
// assumes a serial host on csN/sclk/din, a sampling engine on the clk side
// that digitises analogChanSel after sampleStrobe and pushes the code
//
// Operation
// [RULE1] three-bit select picks input zero to seven, input zero after reset
// [RULE2] results are ten-bit straight binary, all zeros lowest, 1024 steps
// [RULE3] powered up while chip select low, powered down while high; code powers up on falling edge 1, down on edge 16 of each conversion
// [RULE4] continuous mode powers down from falling edge 16 to next edge 1
// [RULE5] each conversion is 16 serial clocks, repeating while chip select low
// [RULE6] host may raise chip select between frames to lower the rate
// [RULE7] four leading zeros, ten bits msb first, two trailing zeros on falls
// [RULE8] control byte shifts in on first eight rises, bits 5..3 select
// [RULE9] output released and serial clock ignored while chip select high
// [RULE10] host frames transfers with whole multiples of 16 rising edges
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_top
	import acs_pkg::*;
#(
	parameter int FIFO_DEPTH = `ACS_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic csN,
	input wire logic din,
	output logic doutData,
	output logic doutOe,
	output logic poweredUp,
	output logic trackActive,
	output logic sampleStrobe,
	output logic [2:0] analogChanSel,
	output logic [`ACS_NUM_CHAN-1:0] analogInputEn,
	input wire logic [`ACS_CODE_BITS-1:0] codeData,
	input wire logic codeValid,
	output logic codeReady
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	acs_sys_t sysQ;
	acs_sys_t sysD;
	acs_rise_frame_t riseFQ;
	acs_rise_frame_t riseFD;
	acs_rise_keep_t riseKQ;
	acs_rise_keep_t riseKD;
	acs_fall_frame_t fallFQ;
	acs_fall_frame_t fallFD;
	acs_fall_keep_t fallKQ;
	acs_fall_keep_t fallKD;

	logic frameRstN;
	logic fifoOutReady;
	logic [`ACS_NUM_CHAN-1:0] chanDecode;
	logic [`ACS_CTRL_BITS-1:0] ctrlByte;
	logic [1:0] rstSync_q;
	logic sysRstN;

	acs_stream_if #(.W(`ACS_CODE_BITS)) fillIf ();
	acs_stream_if #(.W(`ACS_CODE_BITS)) drainIf ();

	// ------------------------------------------------------------------
	// reset release for the clk side
	// ------------------------------------------------------------------
	// asserts at once, releases two clocks later so no flop sees a late edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	assign sysRstN = rstSync_q[1];

	// ------------------------------------------------------------------
	// result buffer
	// ------------------------------------------------------------------
	// the engine is held off by codeReady once FIFO_DEPTH codes wait, sixteen by default
	assign fillIf.valid = codeValid;
	assign fillIf.data = codeData;
	assign codeReady = fillIf.ready;
	assign drainIf.ready = fifoOutReady;

	acs_fifo #(
		.WIDTH(`ACS_CODE_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(sysRstN),
		.fill(fillIf),
		.drain(drainIf)
	);

	// ------------------------------------------------------------------
	// frame reset
	// ------------------------------------------------------------------
	// chip select high clears all per-frame serial state at once, so
	// stray clocks while deselected do nothing
	assign frameRstN = rst_n & ~csN; // RULE9 RULE10

	// ------------------------------------------------------------------
	// channel decode, one enable per analog input
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `ACS_NUM_CHAN; gi++) begin : g_dec
			assign chanDecode[gi] = (sysQ.chan == 3'(gi)); // RULE1
		end
	endgenerate

	// ------------------------------------------------------------------
	// system clock domain: sample request, fetch, hand over
	// ------------------------------------------------------------------
	always_comb begin
		sysD = sysQ;
		fifoOutReady = 1'b0;
		sysD.strobe = 1'b0;
		sysD.chanSync = {sysQ.chanSync[0], riseKQ.chanTog};
		sysD.ackSync = {sysQ.ackSync[0], fallKQ.ackTog};
		sysD.inputEn = chanDecode; // RULE1
		unique case (sysQ.state)
			ST_WAIT_CHAN: begin
				// nextChan is stable long before its toggle arrives here
				if (sysQ.chanSync[1] != sysQ.chanSeen) begin
					sysD.chanSeen = ~sysQ.chanSeen;
					sysD.chan = riseKQ.nextChan; // RULE8
					sysD.state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				sysD.strobe = 1'b1;
				sysD.state = ST_FETCH;
			end
			ST_FETCH: begin
				fifoOutReady = 1'b1;
				if (drainIf.valid) begin
					sysD.holdCode = drainIf.data; // RULE2
					sysD.readyTog = ~sysQ.readyTog;
					sysD.state = ST_OFFER;
				end
			end
			ST_OFFER: begin
				// holdCode must not move until the serial side has taken it
				if (sysQ.ackSync[1] == sysQ.readyTog) begin
					sysD.state = ST_WAIT_CHAN;
				end
			end
			// a non one-hot code falls back to waiting for a channel
			default: begin
				sysD.state = ST_WAIT_CHAN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge sysRstN) begin
		if (!sysRstN) begin
			sysQ <= '{
				state: ST_SAMPLE,
				chan: `ACS_CHAN_DEFAULT,
				inputEn: `ACS_INPUT_EN_RST,
				default: '0
			}; // RULE1
		end else begin
			sysQ <= sysD;
		end
	end

	// ------------------------------------------------------------------
	// serial rising edges: control byte capture
	// ------------------------------------------------------------------
	assign ctrlByte = {riseFQ.ctrlShift, din};

	always_comb begin
		riseFD = riseFQ;
		riseKD = riseKQ;
		// counter wraps so every conversion in a frame takes a new byte
		riseFD.riseCnt = riseFQ.riseCnt + 4'h1; // RULE5
		if (riseFQ.riseCnt < `ACS_CTRL_LAST) begin
			riseFD.ctrlShift = ctrlByte[`ACS_CTRL_BITS-2:0];
		end
		if (riseFQ.riseCnt == `ACS_CTRL_LAST) begin
			riseKD.nextChan = ctrlByte[`ACS_CHAN_MSB:`ACS_CHAN_LSB]; // RULE8
			riseKD.chanTog = ~riseKQ.chanTog;
		end
	end

	always_ff @(posedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			riseFQ <= '0;
		end else begin
			riseFQ <= riseFD;
		end
	end

	// selection survives chip select so burst frames keep their channel
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			riseKQ <= '{nextChan: `ACS_CHAN_DEFAULT, chanTog: 1'b0}; // RULE6
		end else begin
			riseKQ <= riseKD;
		end
	end

	// ------------------------------------------------------------------
	// serial falling edges: shift-out, track/hold, power
	// ------------------------------------------------------------------
	always_comb begin
		fallFD = fallFQ;
		fallKD = fallKQ;
		fallKD.rdySync = {fallKQ.rdySync[0], sysQ.readyTog};
		fallFD.fallCnt = fallFQ.fallCnt + 4'h1; // RULE5
		fallFD.oe = 1'b1; // RULE9
		fallFD.dout = 1'b0; // RULE7
		if (fallFQ.fallCnt == `ACS_TRACK_START) begin
			fallFD.powered = 1'b1; // RULE3 RULE4
			fallFD.track = 1'b1; // RULE7
		end
		if (fallFQ.fallCnt == `ACS_HOLD_START) begin
			fallFD.track = 1'b0; // RULE7
			// an empty hand-over sends a zero code rather than stall the host
			if (fallKQ.rdySync[1] != fallKQ.ackTog) begin
				fallFD.codeShift = sysQ.holdCode; // RULE2
				fallKD.ackTog = ~fallKQ.ackTog;
			end else begin
				fallFD.codeShift = `ACS_CODE_ZERO;
			end
		end
		if (fallFQ.fallCnt >= `ACS_CODE_FIRST && fallFQ.fallCnt <= `ACS_CODE_LAST) begin
			fallFD.dout = fallFQ.codeShift[`ACS_CODE_BITS-1]; // RULE7
			fallFD.codeShift = {fallFQ.codeShift[`ACS_CODE_BITS-2:0], 1'b0};
		end
		if (fallFQ.fallCnt == `ACS_CONV_LAST) begin
			fallFD.powered = 1'b0; // RULE4
		end
	end

	// low power and released output whenever chip select is high
	always_ff @(negedge sclk or negedge frameRstN) begin
		if (!frameRstN) begin
			fallFQ <= '0; // RULE3 RULE9
		end else begin
			fallFQ <= fallFD;
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			fallKQ <= '0;
		end else begin
			fallKQ <= fallKD;
		end
	end

	// ------------------------------------------------------------------
	// outputs, each straight from a flop
	// ------------------------------------------------------------------
	assign doutData = fallFQ.dout;
	assign doutOe = fallFQ.oe;
	assign poweredUp = fallFQ.powered;
	assign trackActive = fallFQ.track;
	assign sampleStrobe = sysQ.strobe;
	assign analogChanSel = sysQ.chan;
	assign analogInputEn = sysQ.inputEn;

endmodule

`default_nettype wire

// ---- testbench/acs_top_sva.sv ----
// assertions on the pins of the converter frame control block
// assumes a host that starts each frame with sclk high
`timescale 1ns/1ps
`default_nettype none

module acs_top_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic csN,
	input wire logic doutData,
	input wire logic doutOe,
	input wire logic poweredUp,
	input wire logic trackActive,
	input wire logic sampleStrobe,
	input wire logic [2:0] analogChanSel,
	input wire logic [7:0] analogInputEn,
	input wire logic codeReady
);
	// ----------------------------------------
	// rises seen so far in this conversion
	// ----------------------------------------
	logic [3:0] riseCnt_q;
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			riseCnt_q <= 4'h0;
		end else begin
			riseCnt_q <= riseCnt_q + 4'h1;
		end
	end

	property p_lead;
		@(posedge sclk) disable iff (!rst_n || csN) riseCnt_q < 4'h4 |-> !doutData;
	endproperty
	a_lead: assert property (p_lead) else $error("leading bit not zero");
	property p_trail;
		@(posedge sclk) disable iff (!rst_n || csN) riseCnt_q > 4'hd |-> !doutData;
	endproperty
	a_trail: assert property (p_trail) else $error("trailing bit not zero");
	property p_track;
		@(posedge sclk) disable iff (!rst_n || csN) 1'b1 |-> trackActive == (riseCnt_q < 4'h3);
	endproperty
	a_track: assert property (p_track) else $error("track window wrong");
	property p_power;
		@(posedge sclk) disable iff (!rst_n || csN) 1'b1 |-> poweredUp == (riseCnt_q != 4'hf);
	endproperty
	a_power: assert property (p_power) else $error("power window wrong");
	property p_oe;
		@(posedge sclk) disable iff (!rst_n || csN) riseCnt_q == 4'h0 |-> doutOe [*8];
	endproperty
	a_oe: assert property (p_oe) else $error("output not driven in frame");
	property p_desel;
		@(posedge clk) disable iff (!rst_n)
			csN && $past(csN) |-> !doutOe && !poweredUp && !trackActive;
	endproperty
	a_desel: assert property (p_desel) else $error("active while deselected");
	property p_onehot;
		@(posedge clk) disable iff (!rst_n) sampleStrobe |-> analogInputEn == 8'h01 << analogChanSel;
	endproperty
	a_onehot: assert property (p_onehot) else $error("input enable mismatch");
	property p_pulse;
		@(posedge clk) disable iff (!rst_n) sampleStrobe |=> !sampleStrobe ##1 !sampleStrobe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("sample strobe too long");
	c_back: cover property (@(posedge sclk) riseCnt_q == 4'hf ##1 !csN);
	c_strobe: cover property (@(posedge clk) sampleStrobe);
	c_full: cover property (@(posedge clk) rst_n && !codeReady);
endmodule

bind acs_top acs_top_sva u_sva (.clk, .rst_n, .sclk, .csN, .doutData, .doutOe, .poweredUp,
	.trackActive, .sampleStrobe, .analogChanSel, .analogInputEn, .codeReady);

`default_nettype wire

// ---- testbench/acs_host.sv ----
// serial host: frames, control bytes, result capture
// assumes the device shifts out on falls; clock parks high between frames
`timescale 1ns/1ps
`default_nettype none

module acs_host (
	output logic sclk,
	output logic csN,
	output logic din,
	input wire logic doutData
);
	initial begin
		sclk = 1'b1;
		csN = 1'b1;
		din = 1'b0;
	end
	// odd offset keeps the link out of step with clk
	task automatic open();
		#7 csN = 1'b0;
		#24;
	endtask
	task automatic conv(input logic [7:0] c, output logic [15:0] w);
		for (int i = 0; i < 16; i++) begin
			sclk = 1'b0;
			din = i < 8 ? c[7 - i] : ~din;
			#24 sclk = 1'b1;
			w = {w[14:0], doutData};
			#24;
		end
	endtask
	task automatic close();
		csN = 1'b1;
		din = ~din;
		#24;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			#24 sclk = 1'b0;
			#24 sclk = 1'b1;
		end
	endtask
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
// bench for the converter frame control block
// assumes the host model and an engine process acting on sampleStrobe
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int D = 4;
	logic clk, rst_n, codeValid, auto;
	logic [9:0] codeData;
	logic [2:0] prev;
	wire logic sclk, csN, din, doutData, doutOe, poweredUp, trackActive, sampleStrobe, codeReady;
	wire logic [2:0] analogChanSel;
	wire logic [7:0] analogInputEn;
	wire logic doutPin;
	// a released line reads as the inverse of the flop, so a late enable shows up
	assign doutPin = doutOe ? doutData : ~doutData;
	int num_errors, check_count;

	acs_top #(.FIFO_DEPTH(D)) DUT (.clk, .rst_n, .sclk, .csN, .din, .doutData, .doutOe,
		.poweredUp, .trackActive, .sampleStrobe, .analogChanSel, .analogInputEn,
		.codeData, .codeValid, .codeReady);
	acs_host host (.sclk, .csN, .din, .doutData(doutPin));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [9:0] cv(input logic [2:0] c);
		return {c, c, c, c[0]};
	endfunction

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// valid stays up across a refusal so the word is held
	task automatic push(input logic [9:0] w, output bit ok);
		ok = 1'b0;
		@(negedge clk);
		codeValid = 1'b1;
		codeData = w;
		for (int i = 0; i < 8 && !ok; i++) begin
			ok = codeReady === 1'b1;
			@(posedge clk);
			if (!ok) @(negedge clk);
		end
	endtask

	// sampling engine: one code per strobe, coded from the channel
	initial begin
		bit ok;
		forever begin
			@(negedge clk);
			if (auto && sampleStrobe === 1'b1) begin
				push(cv(analogChanSel), ok);
				@(negedge clk);
				codeValid = 1'b0;
			end
		end
	end

	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		chk("reset", 16'h8080, {codeReady, analogInputEn, analogChanSel, doutOe, poweredUp,
			trackActive, sampleStrobe});
		rst_n = 1'b1;
		prev = 3'h0;
		repeat (10) @(negedge clk);
		$display("test reset done");
	endtask

	task automatic frame(input int n, input bit fill);
		logic [15:0] w;
		logic [15:0] e;
		logic [2:0] b;
		host.open();
		for (int k = 0; k < n; k++) begin
			b = prev + 3'h1;
			e = {4'h0, cv(prev), 2'h0};
			if (fill) e = k > D ? 16'h0 : {4'h0, 10'h2a0 + 10'(k), 2'h0};
			host.conv({2'h3, b, 3'h5}, w);
			chk("word", e, w);
			prev = b;
		end
		host.close();
	endtask

	task automatic t_burst();
		repeat (3) begin
			host.idle(4);
			frame(1, 1'b0);
			chk("deselected", 16'h0, {14'h0, doutOe, poweredUp});
		end
		$display("test burst done");
	endtask

	task automatic t_fill();
		bit ok;
		int n;
		auto = 1'b0;
		do_reset();
		n = 0;
		for (int i = 0; i <= D + 1; i++) begin
			push(10'h2a0 + 10'(i), ok);
			n += ok;
		end
		@(negedge clk);
		codeValid = 1'b0;
		chk("accepted", 16'(D + 1), 16'(n));
		chk("full", 16'h0, {15'h0, codeReady});
		frame(D + 2, 1'b1);
		$display("test fill done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		codeValid = 1'b0;
		codeData = 10'h000;
		auto = 1'b1;
		prev = 3'h0;
		do_reset();
		frame(9, 1'b0);
		$display("test continuous done");
		t_burst();
		t_fill();
		results();
	end

	initial begin
		#200000;
		num_errors++;
		results();
	end
endmodule

`default_nettype wire
